// *** dv/mfc_app_model.sv ***
`timescale 1ns/1ps
// Far-side application: hands a received header over as four word pulses
module mfc_app_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench commands
  input wire logic hdr_go,
  input wire logic slow,
  input wire logic [31:0] hdr_base,
  // Header words towards the formatter
  output logic [31:0] rx_header_word,
  output logic rx_header_valid,
  output logic hdr_busy
);
  logic [2:0] left_reg;
  logic gap_reg;
  assign hdr_busy = (left_reg != 3'h0) || rx_header_valid;
  // Between pulses the word is inverted each cycle, so over a long idle run the stale value returns every second cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_reg <= 3'h0;
      gap_reg <= 1'h0;
      rx_header_valid <= 1'h0;
      rx_header_word <= 32'h0;
    end
    else if (left_reg != 3'h0 && !gap_reg)
    begin
      left_reg <= left_reg - 3'h1;
      gap_reg <= slow;
      rx_header_valid <= 1'h1;
      rx_header_word <= hdr_base + {29'h0, 3'h4 - left_reg};
    end
    else
    begin
      left_reg <= hdr_go ? 3'h4 : left_reg;
      gap_reg <= 1'h0;
      rx_header_valid <= 1'h0;
      rx_header_word <= ~rx_header_word;
    end
  end
endmodule

// *** dv/mfc_formatter_ctrl_test.sv ***
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_formatter_ctrl_test;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rx_header_word, timestamp_mask, hdr_base = '0, rd, ctrl, v;
  logic [3:0] s_axi_wstrb = 4'hf, blocks_per_source;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic bulk_tx_error_in = 1'h0, bulk_rx_error_out, rx_packet_in = 1'h0, rx_header_valid, rx_status_set = 1'h0;
  logic stream_rx_enable, stream_tx_enable, rx_accept, tx_aging_enable, rx_aging_enable, rx_header_strip, irq;
  logic [2:0] sources_per_packet;
  logic hdr_go = 1'h0, slow = 1'h0, hdr_busy;
  int bad_count = 0, total_checks = 0, cyc = 0;

  mfc_formatter_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bulk_tx_error_in(bulk_tx_error_in), .bulk_rx_error_out(bulk_rx_error_out),
    .rx_packet_in(rx_packet_in), .rx_header_word(rx_header_word), .rx_header_valid(rx_header_valid),
    .rx_status_set(rx_status_set), .stream_rx_enable(stream_rx_enable), .stream_tx_enable(stream_tx_enable),
    .rx_accept(rx_accept), .tx_aging_enable(tx_aging_enable), .rx_aging_enable(rx_aging_enable),
    .rx_header_strip(rx_header_strip), .blocks_per_source(blocks_per_source),
    .sources_per_packet(sources_per_packet), .timestamp_mask(timestamp_mask), .irq(irq));
  mfc_app_model app (.aclk(aclk), .aresetn(aresetn), .hdr_go(hdr_go), .slow(slow), .hdr_base(hdr_base),
    .rx_header_word(rx_header_word), .rx_header_valid(rx_header_valid), .hdr_busy(hdr_busy));

  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // ****
  // Checking
  // ****
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string s);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s resp %h exp %h", $time, s, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_blk(input logic [2:0] c);
    return c < 3'h3 ? 4'h8 >> c : 4'h1;
  endfunction
  function automatic logic [2:0] exp_src(input logic [2:0] c);
    return c[2] ? c - 3'h2 : 3'h1;
  endfunction
  task automatic chk_outs(input logic [31:0] c);
    chk_word(stream_rx_enable, c[0], "rxen");
    chk_word(rx_accept, c[0] & rx_packet_in, "accept");
    chk_word(stream_tx_enable, c[1], "txen");
    chk_word(tx_aging_enable, c[6], "txage");
    chk_word(rx_aging_enable, c[7], "rxage");
    chk_word(blocks_per_source, exp_blk(c[15:13]), "blocks");
    chk_word(sources_per_packet, exp_src(c[15:13]), "sources");
    chk_word(rx_header_strip, c[16], "strip");
    chk_word(timestamp_mask, c[17] ? 32'hffffffff : 32'h01ffffff, "tsmask");
  endtask

  // ****
  // AXI4-Lite master
  // ****
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw = 1'h0;
    bit w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw |= s_axi_awready === 1'h1;
      w |= s_axi_wready === 1'h1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (s_axi_bvalid !== 1'h1)
      @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    chk_resp(resp, mfc_pkg::MFC_RESP_OKAY, "wresp");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
    axi_rd(a, rd, resp);
    chk_resp(resp, mfc_pkg::MFC_RESP_OKAY, s);
    chk_word(rd & m, e & m, s);
  endtask

  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(32'h0593));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    chk_outs(32'h0);
    rd_chk(8'hf0, 32'h0, 32'hffffffff, "rst_main");
    rd_chk(8'hf4, 32'h0, 32'hffffffff, "rst_alias");
    // Every class code three times, written at one address and read back at the other; the first write sets all other bits
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 32'hffffffff : $urandom();
      v[15:13] = i[2:0];
      rx_packet_in <= v[20];
      wr_ok(i[0] ? 8'hf4 : 8'hf0, v);
      ctrl = v & `MFC_CTRL_WMASK;
      rd_chk(i[0] ? 8'hf0 : 8'hf4, ctrl, 32'hffffffff, "ctrl");
      chk_outs(ctrl);
    end
    wr_ok(8'hf0, 32'h20);
    rx_status_set <= 1'h1;
    repeat (4) @(posedge aclk);
    chk_word(bulk_rx_error_out, 32'h1, "rxerr_on");
    rd_chk(8'hfc, 32'h1, 32'h1, "rxstat");
    wr_ok(8'hf0, 32'h0);
    repeat (2) @(posedge aclk);
    chk_word(bulk_rx_error_out, 32'h0, "rxerr_off");
    wr_ok(`MFC_INT_MASK_OFFSET, 32'h2);
    wr_ok(8'hf0, 32'h10);
    bulk_tx_error_in <= 1'h1;
    repeat (6) @(posedge aclk);
    rd_chk(8'hf8, 32'h1, 32'h1, "txstat");
    chk_word(irq, 32'h1, "irq_txerr");
    rd_chk(8'he0, 32'h2, 32'h2, "int_txerr");
    chk_word(irq, 32'h0, "irq_clear");
    // Mode off: the status bit keeps its last value
    wr_ok(8'hf0, 32'h0);
    bulk_tx_error_in <= 1'h0;
    repeat (6) @(posedge aclk);
    rd_chk(8'hf8, 32'h1, 32'h1, "txhold");
    wr_ok(8'hf0, 32'h10000);
    // First pass masked and prompt, second unmasked with a stalling far side
    for (int k = 0; k < 2; k++)
    begin
      wr_ok(`MFC_INT_MASK_OFFSET, {31'h0, k[0]});
      v = $urandom();
      hdr_base <= v;
      slow <= k[0];
      hdr_go <= 1'h1;
      @(posedge aclk);
      hdr_go <= 1'h0;
      // The far side takes the go pulse at this edge, so busy means something one edge later
      @(posedge aclk);
      while (hdr_busy !== 1'h0)
        @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk_word(irq, {31'h0, k[0]}, "irq_hdr");
      for (int j = 0; j < 4; j++)
        rd_chk(8'hc0 + 8'(4 * j), v + 32'(j), 32'hffffffff, "hdrbuf");
      rd_chk(8'he0, 32'h1, 32'h1, "int_hdr");
    end
    axi_wr(8'h10, 32'hffffffff, resp);
    chk_resp(resp, mfc_pkg::MFC_RESP_SLVERR, "wr_unmapped");
    axi_rd(8'h10, rd, resp);
    chk_resp(resp, mfc_pkg::MFC_RESP_SLVERR, "rd_unmapped");
    chk_word(rd, 32'h0, "rd_unmapped_data");
    rd_chk(8'hf4, 32'h10000, 32'hffffffff, "ctrl_kept");
    // Only the lowest byte lane is written; the upper lanes keep their bits
    s_axi_wstrb <= 4'h1;
    wr_ok(8'hf4, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    rd_chk(8'hf0, 32'h000100f3, 32'hffffffff, "ctrl_lane");
    // Second reset in mid-run
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk_outs(32'h0);
    rd_chk(8'hf0, 32'h0, 32'hffffffff, "rst_again");
    print_verdict();
  end
endmodule

// *** verilog/mfc_class_decode.sv ***
`timescale 1ns/1ps
`include "mfc_defs.svh"
// Class code to packing figures
module mfc_class_decode
(
  // Class code
  input wire logic [2:0] tx_class,
  // Packing figures
  output logic [3:0] blocks_per_source,
  output logic [2:0] sources_per_packet
);
  always_comb
  begin
    blocks_per_source = 4'h1;
    sources_per_packet = 3'h1;
    case (mfc_pkg::mfc_class_t'(tx_class))
      mfc_pkg::MFC_SPLIT8: blocks_per_source = 4'h8;
      mfc_pkg::MFC_SPLIT4: blocks_per_source = 4'h4;
      mfc_pkg::MFC_SPLIT2: blocks_per_source = 4'h2;
      mfc_pkg::MFC_WHOLE: sources_per_packet = 3'h1;
      mfc_pkg::MFC_PACK2: sources_per_packet = 3'h2;
      mfc_pkg::MFC_PACK3: sources_per_packet = 3'h3;
      mfc_pkg::MFC_PACK4: sources_per_packet = 3'h4;
      mfc_pkg::MFC_PACK5: sources_per_packet = 3'h5;
      default: sources_per_packet = 3'h1;
    endcase
  end
endmodule

// *** verilog/mfc_defs.svh ***
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH
// Summary of operation
// - Reset clears every control bit to zero
// - Control register also reachable at alias address
// - Bit 0 enables stream receive acceptance
// - Bit 1 enables stream transmit sending
// - Bit 4 mirrors tx error into status
// - Bit 5 drives rx error from status
// - Bit 6 enables transmit aging
// - Bit 7 enables receive aging
// - Class 0-2 splits packet into 8/4/2 blocks
// - Class 3 sends one whole packet each
// - Class 4-7 packs up to 2..5 packets
// - Bit 16 strips headers into buffer registers
// - Bit 17 selects 32-bit else 25-bit timestamp

// ****************************************
// Register offsets
// ****************************************
`define MFC_CTRL_OFFSET 8'hf0
`define MFC_CTRL_ALIAS_OFFSET 8'hf4
`define MFC_TX_STATUS_OFFSET 8'hf8
`define MFC_RX_STATUS_OFFSET 8'hfc
`define MFC_INT_STATUS_OFFSET 8'he0
`define MFC_INT_MASK_OFFSET 8'he4
`define MFC_HDR_BUF0_OFFSET 8'hc0

// ****************************************
// Field positions and reset values
// ****************************************
`define MFC_RX_EN_BIT 0
`define MFC_TX_EN_BIT 1
`define MFC_TXERR_MODE_BIT 4
`define MFC_RXERR_MODE_BIT 5
`define MFC_TX_AGE_BIT 6
`define MFC_RX_AGE_BIT 7
`define MFC_CLASS_LSB 13
`define MFC_CLASS_MSB 15
`define MFC_HDR_STRIP_BIT 16
`define MFC_EXT_TS_BIT 17
`define MFC_CTRL_WMASK 32'h0003e0f3
`define MFC_CTRL_RESET 32'h00000000
`define MFC_HDR_WORDS 4
`define MFC_TS_SHORT_MASK 32'h01ffffff
`define MFC_TS_LONG_MASK 32'hffffffff
`endif

// *** verilog/mfc_err_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for an external error pin
module mfc_err_sync
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin in, synchronised out
  input wire logic pin,
  output logic level
);
  logic meta_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      level <= meta_reg;
    end
  end
endmodule

// *** verilog/mfc_formatter_ctrl.sv ***
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_formatter_ctrl
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bulk data interface error pins
  input wire logic bulk_tx_error_in,
  output logic bulk_rx_error_out,
  // Formatter events
  input wire logic rx_packet_in,
  input wire logic [31:0] rx_header_word,
  input wire logic rx_header_valid,
  input wire logic rx_status_set,
  // Formatter controls
  output logic stream_rx_enable,
  output logic stream_tx_enable,
  output logic rx_accept,
  output logic tx_aging_enable,
  output logic rx_aging_enable,
  output logic rx_header_strip,
  output logic [3:0] blocks_per_source,
  output logic [2:0] sources_per_packet,
  output logic [31:0] timestamp_mask,
  // Interrupt
  output logic irq
);
  logic [31:0] formatter_control_reg;
  logic [31:0] tx_status_reg;
  logic [31:0] rx_status_reg;
  logic [1:0] int_status_reg;
  logic [1:0] int_mask_reg;
  logic [31:0] hdr_buf [0:`MFC_HDR_WORDS-1];
  logic [1:0] hdr_idx_reg;
  logic tx_err_sync;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic do_read;
  logic [31:0] rdata_next;
  logic rd_hit;
  logic wr_hit;
  logic rd_int_status;
  logic tx_err_prev_reg;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == `MFC_CTRL_OFFSET) || (a == `MFC_CTRL_ALIAS_OFFSET);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  mfc_err_sync u_tx_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(bulk_tx_error_in),
    .level(tx_err_sync)
  );

  // ****************************************
  // Write channel
  // ****************************************
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg;
  assign wr_hit = is_ctrl(awaddr_reg) || (awaddr_reg == `MFC_INT_MASK_OFFSET);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? mfc_pkg::MFC_RESP_OKAY : mfc_pkg::MFC_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      formatter_control_reg <= `MFC_CTRL_RESET;
      int_mask_reg <= 2'h0;
    end
    else if (do_write)
    begin
      if (is_ctrl(awaddr_reg))
      begin
        formatter_control_reg <= merge(formatter_control_reg, wdata_reg, wstrb_reg) & `MFC_CTRL_WMASK;
      end
      if (awaddr_reg == `MFC_INT_MASK_OFFSET)
      begin
        int_mask_reg <= wstrb_reg[0] ? wdata_reg[1:0] : int_mask_reg;
      end
    end
  end

  // ****************************************
  // Decoded controls
  // ****************************************
  assign stream_rx_enable = formatter_control_reg[`MFC_RX_EN_BIT];
  assign rx_accept = stream_rx_enable && rx_packet_in;
  assign stream_tx_enable = formatter_control_reg[`MFC_TX_EN_BIT];
  assign tx_aging_enable = formatter_control_reg[`MFC_TX_AGE_BIT];
  assign rx_aging_enable = formatter_control_reg[`MFC_RX_AGE_BIT];
  assign rx_header_strip = formatter_control_reg[`MFC_HDR_STRIP_BIT];
  assign timestamp_mask = formatter_control_reg[`MFC_EXT_TS_BIT] ? `MFC_TS_LONG_MASK :
    `MFC_TS_SHORT_MASK;

  mfc_class_decode u_class
  (
    .tx_class(formatter_control_reg[`MFC_CLASS_MSB:`MFC_CLASS_LSB]),
    .blocks_per_source(blocks_per_source),
    .sources_per_packet(sources_per_packet)
  );

  // ****************************************
  // Error mirroring and status
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_status_reg <= 32'h00000000;
      rx_status_reg <= 32'h00000000;
      bulk_rx_error_out <= 1'b0;
    end
    else
    begin
      if (formatter_control_reg[`MFC_TXERR_MODE_BIT])
      begin
        tx_status_reg[0] <= tx_err_sync;
      end
      rx_status_reg[0] <= rx_status_set;
      bulk_rx_error_out <= formatter_control_reg[`MFC_RXERR_MODE_BIT] && rx_status_reg[0];
    end
  end

  // ****************************************
  // Header buffer
  // ****************************************
  // Headers are kept only when stripping, so the app sees bare source packets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hdr_idx_reg <= 2'h0;
    end
    else if (rx_header_strip && rx_header_valid)
    begin
      hdr_buf[hdr_idx_reg] <= rx_header_word;
      hdr_idx_reg <= hdr_idx_reg + 2'h1;
    end
  end

  // ****************************************
  // Interrupt status, cleared on read
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_status_reg <= 2'h0;
      tx_err_prev_reg <= 1'b0;
    end
    else
    begin
      // Set beats the clear of the same cycle; a held error level raises the flag once
      tx_err_prev_reg <= tx_err_sync;
      int_status_reg <= (rd_int_status ? 2'h0 : int_status_reg) |
        {tx_err_sync && !tx_err_prev_reg, rx_header_strip && rx_header_valid && hdr_idx_reg == 2'h3};
    end
  end
  assign irq = |(int_status_reg & int_mask_reg);

  // ****************************************
  // Read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_int_status = do_read && ({s_axi_araddr[7:2], 2'b00} == `MFC_INT_STATUS_OFFSET);

  always_comb
  begin
    rdata_next = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `MFC_CTRL_OFFSET, `MFC_CTRL_ALIAS_OFFSET: rdata_next = formatter_control_reg;
      `MFC_TX_STATUS_OFFSET: rdata_next = tx_status_reg;
      `MFC_RX_STATUS_OFFSET: rdata_next = rx_status_reg;
      `MFC_INT_STATUS_OFFSET: rdata_next = {30'h0, int_status_reg};
      `MFC_INT_MASK_OFFSET: rdata_next = {30'h0, int_mask_reg};
      `MFC_HDR_BUF0_OFFSET: rdata_next = hdr_buf[0];
      8'hc4: rdata_next = hdr_buf[1];
      8'hc8: rdata_next = hdr_buf[2];
      8'hcc: rdata_next = hdr_buf[3];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rd_hit ? mfc_pkg::MFC_RESP_OKAY : mfc_pkg::MFC_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_reset_clear: assert property (@(posedge aclk) !aresetn |=> formatter_control_reg == 32'h0)
    else $error("control not cleared by reset");
  a_alias_same: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_reg == `MFC_CTRL_ALIAS_OFFSET && wstrb_reg == 4'hf |=>
    formatter_control_reg == ($past(wdata_reg) & `MFC_CTRL_WMASK))
    else $error("alias write lost");
  a_rx_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_accept |-> formatter_control_reg[0])
    else $error("rx accepted while disabled");
  a_tx_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && is_ctrl(awaddr_reg) && wstrb_reg[0] |=> stream_tx_enable == $past(wdata_reg[1]))
    else $error("tx enable mismatch");
  a_tx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    formatter_control_reg[4] && $past(formatter_control_reg[4]) |-> tx_status_reg[0] == $past(tx_err_sync))
    else $error("tx error not mirrored");
  a_rx_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 bulk_rx_error_out == ($past(formatter_control_reg[5]) && $past(rx_status_reg[0])))
    else $error("rx error output wrong");
  a_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (formatter_control_reg & ~`MFC_CTRL_WMASK) == 32'h0)
    else $error("unused bit set");
  a_ts_width: assert property (@(posedge aclk) disable iff (!aresetn)
    !formatter_control_reg[17] |-> timestamp_mask == 32'h01ffffff)
    else $error("timestamp width wrong");
  a_split8: assert property (@(posedge aclk) disable iff (!aresetn)
    formatter_control_reg[15:13] == 3'h0 |-> blocks_per_source == 4'h8)
    else $error("split8 wrong");
  a_pack5: assert property (@(posedge aclk) disable iff (!aresetn)
    formatter_control_reg[15:13] == 3'h7 |-> sources_per_packet == 3'h5)
    else $error("pack5 wrong");
  c_write_ctrl: cover property (@(posedge aclk) do_write && is_ctrl(awaddr_reg));
  c_read_alias: cover property (@(posedge aclk) do_read && s_axi_araddr == `MFC_CTRL_ALIAS_OFFSET);
  c_irq: cover property (@(posedge aclk) irq);
endmodule

// *** verilog/mfc_pkg.sv ***
package mfc_pkg;
  typedef enum logic [2:0] {MFC_SPLIT8, MFC_SPLIT4, MFC_SPLIT2, MFC_WHOLE, MFC_PACK2, MFC_PACK3, MFC_PACK4,
                            MFC_PACK5} mfc_class_t;
  typedef enum logic [1:0] {MFC_RESP_OKAY = 2'b00, MFC_RESP_SLVERR = 2'b10} mfc_resp_t;
endpackage
